// [hw/nomc_mode_ctrl.sv]
// operation control and mode definition registers with APB access
`timescale 1ns/1ps
module nomc_mode_ctrl
(
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic                    POR,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [31:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  input  wire logic [3:0]              PSTRB,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    CRYSTAL_STABLE_FLAG,
  input  wire logic                    FIELD_ON_CMD,
  input  wire logic                    TX_FINISHED,
  input  wire logic                    TRANSPORT_FRAME_INSERT,
  output nomc_pkg::nomc_ctrl_out_t     CTRL,
  output nomc_pkg::nomc_proto_t        PROTOCOL,
  output logic                         RATE_DETECT_F,
  output logic                         RATE_DETECT_A,
  output logic                         RECEIVE_CHANNEL_CHOICE
);
  typedef struct packed {
    nomc_pkg::nomc_op_ctrl_t   op;
    nomc_pkg::nomc_mode_def_t  md;
    logic                      rx_choice;
    logic                      ev_field_on;
    logic                      ev_tx_done;
    logic                      frame_conflict;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    nomc_pkg::nomc_ctrl_out_t  ctrl;
    nomc_pkg::nomc_proto_t     proto;
    logic                      rd_f;
    logic                      rd_a;
  } nomc_state_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_OP,
    SEL_MODE,
    SEL_EVENT,
    SEL_STATUS,
    SEL_RX_CFG
  } nomc_sel_t;

  nomc_state_t           st_ff;
  nomc_state_t           nxt_st;
  nomc_pkg::nomc_decode_t dec;
  logic                  osc_ok;
  logic                  frame_insert;
  logic                  access;
  nomc_sel_t             sel;
  // hardware events seen this cycle
  logic                  tx_done_evt;
  logic                  frame_evt;

  // crystal flag and frame option come from other domains
  nomc_sync u_sync_osc
  (
    .CLK (CLK),
    .RST (RST),
    .d   (CRYSTAL_STABLE_FLAG),
    .q   (osc_ok)
  );

  nomc_sync u_sync_frame
  (
    .CLK (CLK),
    .RST (RST),
    .d   (TRANSPORT_FRAME_INSERT),
    .q   (frame_insert)
  );

  nomc_mode_decode u_dec
  (
    .mode_def (st_ff.md),
    .dec      (dec)
  );

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? wd[7:0] : old_v;
  endfunction

  // one address decode shared by the read and write paths
  function automatic nomc_sel_t sel_of(input logic [31:0] a);
    if (a == nomc_pkg::ADDR_OP_CTRL)
    begin
      sel_of = SEL_OP;
    end
    else if (a == nomc_pkg::ADDR_MODE_DEF)
    begin
      sel_of = SEL_MODE;
    end
    else if (a == nomc_pkg::ADDR_EVENT)
    begin
      sel_of = SEL_EVENT;
    end
    else if (a == nomc_pkg::ADDR_STATUS)
    begin
      sel_of = SEL_STATUS;
    end
    else if (a == nomc_pkg::ADDR_RX_CFG)
    begin
      sel_of = SEL_RX_CFG;
    end
    else
    begin
      // anything else is refused with an error
      sel_of = SEL_NONE;
    end
  endfunction

  // write one to clear; an event in the same cycle keeps the flag set
  function automatic logic w1c(input logic flag,
                               input logic clr,
                               input logic set);
    w1c = (flag & ~clr) | set;
  endfunction

  // a channel runs with reception on when both run or it is the chosen one
  function automatic logic chan_on(input logic rx_en,
                                   input logic single,
                                   input logic pick);
    chan_on = rx_en & (~single | pick);
  endfunction

  // status word: crystal, mode validity, low power and protocol
  function automatic logic [31:0] status_word(input logic                  xtal,
                                              input logic                  valid,
                                              input logic                  low_pow,
                                              input nomc_pkg::nomc_proto_t pr);
    status_word      = 32'h0000_0000;
    status_word[0]   = xtal;
    status_word[1]   = valid;
    status_word[2]   = low_pow;
    status_word[7:4] = pr;
  endfunction

  // the pready guard keeps one access from being taken twice
  assign access = PSEL & PENABLE & ~st_ff.pready;
  assign sel    = sel_of(PADDR);
  assign tx_done_evt = TX_FINISHED & ~FIELD_ON_CMD
                       & (dec.proto == nomc_pkg::NOMC_PROTO_ACTIVE_P2P);
  assign frame_evt   = frame_insert & (dec.proto == nomc_pkg::NOMC_PROTO_RATE_DETECT);

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    // hardware transmit updates; a field-on still wins over a host write below
    if (FIELD_ON_CMD)
    begin
      nxt_st.op.transmit_switch = 1'b1;
      nxt_st.ev_field_on        = 1'b1;
    end
    else if (tx_done_evt)
    begin
      nxt_st.op.transmit_switch = 1'b0;
      nxt_st.ev_tx_done         = 1'b1;
    end
    if (frame_evt)
    begin
      nxt_st.frame_conflict = 1'b1;
    end

    if (access)
    begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h0000_0000;
      if (sel == SEL_OP)
      begin
        if (PWRITE)
        begin
          nxt_st.op = merge_byte(st_ff.op, PWDATA, PSTRB);
          if (FIELD_ON_CMD)
          begin
            nxt_st.op.transmit_switch = 1'b1;
          end
        end
        else
        begin
          nxt_st.prdata[7:0] = st_ff.op;
        end
      end
      else if (sel == SEL_MODE)
      begin
        if (PWRITE)
        begin
          if (osc_ok)
          begin
            nxt_st.md = merge_byte(st_ff.md, PWDATA, PSTRB);
          end
          else
          begin
            nxt_st.pslverr = 1'b1;
          end
        end
        else
        begin
          nxt_st.prdata[7:0] = st_ff.md;
        end
      end
      else if (sel == SEL_EVENT)
      begin
        if (PWRITE)
        begin
          // a same-cycle event keeps the flag set
          nxt_st.ev_field_on    = w1c(st_ff.ev_field_on,
                                      PWDATA[nomc_pkg::EV_FIELD_ON_POS], FIELD_ON_CMD);
          nxt_st.ev_tx_done     = w1c(st_ff.ev_tx_done,
                                      PWDATA[nomc_pkg::EV_TX_DONE_POS], tx_done_evt);
          nxt_st.frame_conflict = w1c(st_ff.frame_conflict,
                                      PWDATA[nomc_pkg::EV_ACTIVE_POS], frame_evt);
        end
        else
        begin
          nxt_st.prdata[nomc_pkg::EV_FIELD_ON_POS] = st_ff.ev_field_on;
          nxt_st.prdata[nomc_pkg::EV_TX_DONE_POS]  = st_ff.ev_tx_done;
          nxt_st.prdata[nomc_pkg::EV_ACTIVE_POS]   = st_ff.frame_conflict;
        end
      end
      else if (sel == SEL_STATUS)
      begin
        if (PWRITE)
        begin
          nxt_st.pslverr = 1'b1;
        end
        else
        begin
          nxt_st.prdata = status_word(osc_ok, dec.mode_valid,
                                      st_ff.ctrl.low_power_initial, st_ff.proto);
        end
      end
      else if (sel == SEL_RX_CFG)
      begin
        if (PWRITE)
        begin
          nxt_st.rx_choice = PSTRB[0] ? PWDATA[0] : st_ff.rx_choice;
        end
        else
        begin
          nxt_st.prdata[0] = st_ff.rx_choice;
        end
      end
      else
      begin
        nxt_st.pslverr = 1'b1;
      end
    end

    // outputs registered from the current register contents
    nxt_st.ctrl.osc_reg_enable = st_ff.op.ready_mode_switch;
    nxt_st.ctrl.rx_active      = st_ff.op.receive_enable & dec.mode_valid;
    nxt_st.ctrl.rx_am_channel  = chan_on(st_ff.op.receive_enable,
                                         st_ff.op.single_receive_channel, ~st_ff.rx_choice);
    nxt_st.ctrl.rx_pm_channel  = chan_on(st_ff.op.receive_enable,
                                         st_ff.op.single_receive_channel, st_ff.rx_choice);
    nxt_st.ctrl.rx_auto_select = ~st_ff.op.single_receive_channel
                                 & ~st_ff.op.manual_channel_choice;
    nxt_st.ctrl.tx_active      = st_ff.op.transmit_switch & dec.mode_valid;
    nxt_st.ctrl.wakeup_active  = st_ff.op.wakeup_mode_switch;
    nxt_st.ctrl.field_detector_mode = st_ff.op.field_detector_ctrl;
    nxt_st.ctrl.low_power_initial   = (st_ff.op.field_detector_ctrl != nomc_pkg::FD_OFF)
                                      & (st_ff.op[7:2] == 6'h00);
    nxt_st.ctrl.modulation_am       = st_ff.md.modulation_kind_select;
    // reserved setting behaves as off
    nxt_st.ctrl.auto_response_mode  = (st_ff.md.auto_response_field == 2'h3)
                                      ? nomc_pkg::AR_OFF : st_ff.md.auto_response_field;
    nxt_st.ctrl.use_passive_resistance = dec.target_role & dec.passive_target;
    nxt_st.proto = dec.proto;
    nxt_st.rd_f  = dec.rate_detect_f;
    nxt_st.rd_a  = dec.rate_detect_a;
  end

  always_ff @(posedge CLK)
  begin
    if (POR)
    begin
      st_ff       <= '0;
      st_ff.op    <= nomc_pkg::OP_CTRL_RESET;
      st_ff.md    <= nomc_pkg::MODE_DEF_RESET;
      st_ff.proto <= nomc_pkg::NOMC_PROTO_NONE;
    end
    else if (RST)
    begin
      // ordinary reset keeps operation control; mode, receive choice, bus, events and outputs restart
      st_ff.md             <= nomc_pkg::MODE_DEF_RESET;
      st_ff.rx_choice      <= nomc_pkg::RX_CFG_RESET;
      st_ff.ev_field_on    <= 1'b0;
      st_ff.ev_tx_done     <= 1'b0;
      st_ff.frame_conflict <= 1'b0;
      st_ff.prdata         <= 32'h0000_0000;
      st_ff.pready         <= 1'b0;
      st_ff.pslverr        <= 1'b0;
      st_ff.ctrl           <= '0;
      st_ff.proto          <= nomc_pkg::NOMC_PROTO_NONE;
      st_ff.rd_f           <= 1'b0;
      st_ff.rd_a           <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign PRDATA                 = st_ff.prdata;
  assign PREADY                 = st_ff.pready;
  assign PSLVERR                = st_ff.pslverr;
  assign CTRL                   = st_ff.ctrl;
  assign PROTOCOL               = st_ff.proto;
  assign RATE_DETECT_F          = st_ff.rd_f;
  assign RATE_DETECT_A          = st_ff.rd_a;
  assign RECEIVE_CHANNEL_CHOICE = st_ff.rx_choice;
endmodule // nomc_mode_ctrl

// [include/nomc_pkg.sv]
// package: register map, field positions, resets and decoded types for mode control
package nomc_pkg;
  // register index; the bus address is four times the index
  localparam int          IDX_OP_CTRL    = 2;
  localparam int          IDX_MODE_DEF   = 3;
  localparam logic [31:0] ADDR_OP_CTRL   = 32'(IDX_OP_CTRL * 4);
  localparam logic [31:0] ADDR_MODE_DEF  = 32'(IDX_MODE_DEF * 4);
  localparam logic [31:0] ADDR_EVENT     = 32'h0000_0010;
  localparam logic [31:0] ADDR_STATUS    = 32'h0000_0014;
  localparam logic [31:0] ADDR_RX_CFG    = 32'h0000_0018;
  localparam int OP_READY_POS    = 7;
  localparam int OP_RX_EN_POS    = 6;
  localparam int OP_SINGLE_POS   = 5;
  localparam int OP_MANUAL_POS   = 4;
  localparam int OP_TX_POS       = 3;
  localparam int OP_WAKEUP_POS   = 2;
  localparam int MD_TARGET_POS   = 7;
  localparam int MD_OM_HI        = 6;
  localparam int MD_OM_LO        = 3;
  localparam int MD_AM_POS       = 2;
  localparam int EV_FIELD_ON_POS = 0;
  localparam int EV_TX_DONE_POS  = 1;
  localparam int EV_ACTIVE_POS   = 2;
  localparam logic [7:0] OP_CTRL_RESET  = 8'h00;
  localparam logic [7:0] MODE_DEF_RESET = 8'h08;
  localparam logic [0:0] RX_CFG_RESET   = 1'h0;
  localparam logic [1:0] FD_OFF         = 2'h0;
  localparam logic [1:0] FD_COLL_AVOID  = 2'h1;
  localparam logic [1:0] FD_PEER        = 2'h2;
  localparam logic [1:0] FD_AUTO        = 2'h3;
  localparam logic [1:0] AR_OFF         = 2'h0;
  localparam logic [1:0] AR_ANY_RX      = 2'h1;
  localparam logic [1:0] AR_PEER_OFF    = 2'h2;
  localparam logic [3:0] OM_I_ACTIVE    = 4'h0;
  localparam logic [3:0] OM_I_ISO_A     = 4'h1;
  localparam logic [3:0] OM_I_ISO_B     = 4'h2;
  localparam logic [3:0] OM_I_NFC_F     = 4'h3;
  localparam logic [3:0] OM_I_TYPE1     = 4'h4;
  localparam logic [3:0] OM_I_SUBC      = 4'hE;
  localparam logic [3:0] OM_I_BPSK      = 4'hF;
  localparam logic [3:0] OM_T_ISO_A     = 4'h1;
  localparam logic [3:0] OM_T_NFC_F     = 4'h4;
  localparam logic [3:0] OM_T_ACTIVE    = 4'h7;

  typedef enum logic [3:0] {
    NOMC_PROTO_NONE,
    NOMC_PROTO_ACTIVE_P2P,
    NOMC_PROTO_ISO_A,
    NOMC_PROTO_ISO_B,
    NOMC_PROTO_NFC_F,
    NOMC_PROTO_TYPE1,
    NOMC_PROTO_SUBC_STREAM,
    NOMC_PROTO_BPSK_STREAM,
    NOMC_PROTO_RATE_DETECT
  } nomc_proto_t;

  typedef struct packed {
    logic        ready_mode_switch;
    logic        receive_enable;
    logic        single_receive_channel;
    logic        manual_channel_choice;
    logic        transmit_switch;
    logic        wakeup_mode_switch;
    logic [1:0]  field_detector_ctrl;
  } nomc_op_ctrl_t;

  typedef struct packed {
    logic        listener_role_select;
    logic [3:0]  operating_mode;
    logic        modulation_kind_select;
    logic [1:0]  auto_response_field;
  } nomc_mode_def_t;

  typedef struct packed {
    nomc_proto_t proto;
    logic        mode_valid;
    logic        target_role;
    logic        passive_target;
    logic        rate_detect_f;
    logic        rate_detect_a;
  } nomc_decode_t;

  typedef struct packed {
    logic        osc_reg_enable;
    logic        rx_active;
    logic        rx_am_channel;
    logic        rx_pm_channel;
    logic        rx_auto_select;
    logic        tx_active;
    logic        wakeup_active;
    logic [1:0]  field_detector_mode;
    logic        low_power_initial;
    logic        modulation_am;
    logic [1:0]  auto_response_mode;
    logic        use_passive_resistance;
  } nomc_ctrl_out_t;
endpackage

// [hw/nomc_sync.sv]
// two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module nomc_sync
(
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } nomc_sync_st_t;

  nomc_sync_st_t st_ff;
  nomc_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule // nomc_sync

// [hw/nomc_mode_decode.sv]
// decodes the mode definition register into protocol and validity
`timescale 1ns/1ps
module nomc_mode_decode
(
  input  nomc_pkg::nomc_mode_def_t mode_def,
  output nomc_pkg::nomc_decode_t   dec
);
  logic [3:0] om;

  always_comb
  begin
    om                 = mode_def.operating_mode;
    dec                = '0;
    dec.proto          = nomc_pkg::NOMC_PROTO_NONE;
    dec.target_role    = mode_def.listener_role_select;
    if (!mode_def.listener_role_select)
    begin
      dec.mode_valid = 1'b1;
      case (om)
        nomc_pkg::OM_I_ACTIVE: dec.proto = nomc_pkg::NOMC_PROTO_ACTIVE_P2P;
        nomc_pkg::OM_I_ISO_A:  dec.proto = nomc_pkg::NOMC_PROTO_ISO_A;
        nomc_pkg::OM_I_ISO_B:  dec.proto = nomc_pkg::NOMC_PROTO_ISO_B;
        nomc_pkg::OM_I_NFC_F:  dec.proto = nomc_pkg::NOMC_PROTO_NFC_F;
        nomc_pkg::OM_I_TYPE1:  dec.proto = nomc_pkg::NOMC_PROTO_TYPE1;
        nomc_pkg::OM_I_SUBC:   dec.proto = nomc_pkg::NOMC_PROTO_SUBC_STREAM;
        nomc_pkg::OM_I_BPSK:   dec.proto = nomc_pkg::NOMC_PROTO_BPSK_STREAM;
        default:               dec.mode_valid = 1'b0;
      endcase
    end
    else if (om[3])
    begin
      // rate detection needs at least one detector enabled; bit 1 ignored
      dec.proto          = nomc_pkg::NOMC_PROTO_RATE_DETECT;
      dec.rate_detect_f  = om[2];
      dec.rate_detect_a  = om[0];
      dec.mode_valid     = om[2] | om[0];
      dec.passive_target = 1'b1;
    end
    else
    begin
      dec.mode_valid = 1'b1;
      case (om)
        nomc_pkg::OM_T_ISO_A:
        begin
          dec.proto          = nomc_pkg::NOMC_PROTO_ISO_A;
          dec.passive_target = 1'b1;
        end
        nomc_pkg::OM_T_NFC_F:
        begin
          dec.proto          = nomc_pkg::NOMC_PROTO_NFC_F;
          dec.passive_target = 1'b1;
        end
        nomc_pkg::OM_T_ACTIVE: dec.proto = nomc_pkg::NOMC_PROTO_ACTIVE_P2P;
        default:               dec.mode_valid = 1'b0;
      endcase
    end
  end
endmodule // nomc_mode_decode

// [verification/nomc_mode_ctrl_monitor.sv]
// checker: bus timing and control output relations of mode control
`timescale 1ns/1ps
module nomc_mode_ctrl_chk
(
  input wire logic                     CLK,
  input wire logic                     RST,
  input wire logic                     POR,
  input wire logic                     PSEL,
  input wire logic                     PENABLE,
  input wire logic                     PWRITE,
  input wire logic [31:0]              PADDR,
  input wire logic [31:0]              PWDATA,
  input wire logic [3:0]               PSTRB,
  input wire logic                     PREADY,
  input wire logic                     PSLVERR,
  input wire logic                     FIELD_ON_CMD,
  input wire nomc_pkg::nomc_ctrl_out_t CTRL,
  input wire nomc_pkg::nomc_proto_t    PROTOCOL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST || POR);
  logic mwr;
  assign mwr = PREADY && !PSLVERR && PWRITE && PSTRB[0] && PADDR == nomc_pkg::ADDR_MODE_DEF;
  a_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_mode_fields: assert property (mwr |=> CTRL.modulation_am == $past(PWDATA[2])
    && CTRL.auto_response_mode == ($past(PWDATA[1:0]) == 2'h3 ? 2'h0 : $past(PWDATA[1:0])))
    else $error("modulation or auto response not following mode write");
  // no bus traffic, so the mode cannot change under the set
  a_field_on_tx: assert property (FIELD_ON_CMD && !PSEL && CTRL.osc_reg_enable
    && PROTOCOL != nomc_pkg::NOMC_PROTO_NONE
    && PROTOCOL != nomc_pkg::NOMC_PROTO_RATE_DETECT |=> ##1 CTRL.tx_active)
    else $error("field on did not set transmit");
  a_invalid_quiet: assert property (PROTOCOL == nomc_pkg::NOMC_PROTO_NONE
    |-> !CTRL.tx_active && !CTRL.rx_active)
    else $error("transfer active with unsupported mode");
  a_low_power: assert property (CTRL.low_power_initial |-> CTRL.field_detector_mode != 2'h0
    && !CTRL.osc_reg_enable && !CTRL.rx_active && !CTRL.tx_active && !CTRL.wakeup_active)
    else $error("low power state with other controls on");
  a_por_clear: assert property (disable iff (RST) POR |=> CTRL == '0
    && PROTOCOL == nomc_pkg::NOMC_PROTO_NONE)
    else $error("outputs not cleared by power-up reset");
  c_field_on: cover property (FIELD_ON_CMD ##2 CTRL.tx_active);
  c_low_power: cover property (CTRL.low_power_initial);
  c_refused: cover property (PSLVERR);
endmodule // nomc_mode_ctrl_chk

bind nomc_mode_ctrl nomc_mode_ctrl_chk chk (.CLK(CLK), .RST(RST), .POR(POR), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .FIELD_ON_CMD(FIELD_ON_CMD), .CTRL(CTRL),
  .PROTOCOL(PROTOCOL));

// [verification/tb_nomc_mode_ctrl.sv]
// testbench: register access, decode and transmit switch of mode control
`timescale 1ns/1ps
module tb_nomc_mode_ctrl;
  localparam logic [31:0] op_a = nomc_pkg::ADDR_OP_CTRL;
  localparam logic [31:0] md_a = nomc_pkg::ADDR_MODE_DEF;
  logic                     CLK = 1'b0;
  logic                     RST = 1'b1;
  logic                     POR = 1'b1;
  logic                     PSEL = 1'b0;
  logic                     PENABLE = 1'b0;
  logic                     PWRITE = 1'b0;
  logic [31:0]              PADDR = 32'h0;
  logic [31:0]              PWDATA = 32'h0;
  logic [31:0]              PRDATA;
  logic                     PREADY;
  logic                     PSLVERR;
  logic                     XTAL = 1'b0;
  logic                     FON = 1'b0;
  logic                     TXF = 1'b0;
  logic                     TFI = 1'b0;
  nomc_pkg::nomc_ctrl_out_t CTRL;
  nomc_pkg::nomc_proto_t    PROTOCOL;
  logic                     RDF;
  logic                     RDA;
  logic                     RCC;
  int                       failures = 0;
  int                       tests_run = 0;
  int                       cycles = 0;
  logic [31:0]              rd;
  logic                     er;
  logic [15:0]              e;
  // mode byte, protocol in enum order, passive, rate f, rate a
  logic [15:0]              tab [15] = '{16'h0110, 16'h0E20, 16'h1330, 16'h1840, 16'h2450,
    16'h7060, 16'h7870, 16'h2800, 16'h8824, 16'hA044, 16'hB810, 16'h9000, 16'hE887,
    16'hE086, 16'hC885};

  always #25 CLK = ~CLK;

  nomc_mode_ctrl dut (.CLK(CLK), .RST(RST), .POR(POR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CRYSTAL_STABLE_FLAG(XTAL), .FIELD_ON_CMD(FON),
    .TX_FINISHED(TXF), .TRANSPORT_FRAME_INSERT(TFI), .CTRL(CTRL), .PROTOCOL(PROTOCOL),
    .RATE_DETECT_F(RDF), .RATE_DETECT_A(RDA), .RECEIVE_CHANNEL_CHOICE(RCC));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, s, x);
    end
  endtask

  // request held until ready is seen at an edge, released after it
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic x);
    xfer(a, 1'b1, d);
    chk({31'h0, er}, {31'h0, x});
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0);
    chk(rd, x);
  endtask

  task automatic pulse(input logic f);
    if (f) FON <= 1'b1; else TXF <= 1'b1;
    @(posedge CLK);
    FON <= 1'b0;
    TXF <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask

  // long enough for every scenario with margin
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      complete_run();
    end
  end

  initial
  begin
    repeat (16) @(posedge CLK);
    POR <= 1'b0;
    RST <= 1'b0;
    @(posedge CLK);
    rdchk(op_a, 32'h0);
    rdchk(md_a, 32'h8);
    chk(32'(PROTOCOL), 32'h2);
    wr(md_a, 32'h0, 1'b1);
    rdchk(md_a, 32'h8);
    XTAL <= 1'b1;
    repeat (4) @(posedge CLK);
    wr(op_a, 32'hC0, 1'b0);
    chk(32'(CTRL[13:9]), 32'h1F);
    wr(op_a, 32'hD0, 1'b0);
    chk(32'(CTRL[13:9]), 32'h1E);
    wr(op_a, 32'hE0, 1'b0);
    chk(32'(CTRL[13:10]), 32'hE);
    wr(nomc_pkg::ADDR_RX_CFG, 32'h1, 1'b0);
    chk(32'({RCC, CTRL[13:10]}), 32'h1D);
    wr(op_a, 32'h80, 1'b0);
    chk(32'(CTRL[13:12]), 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      wr(op_a, i, 1'b0);
      chk(32'(CTRL.field_detector_mode), i);
      chk(32'(CTRL.low_power_initial), 32'(i != 0));
    end
    wr(op_a, 32'h81, 1'b0);
    chk(32'(CTRL.low_power_initial), 32'h0);
    wr(op_a, 32'h84, 1'b0);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rdchk(op_a, 32'h84);
    chk(32'(CTRL.wakeup_active), 32'h1);
    wr(op_a, 32'hC0, 1'b0);
    foreach (tab[i])
    begin
      e = tab[i];
      wr(md_a, e[15:8], 1'b0);
      rdchk(md_a, e[15:8]);
      chk(32'(PROTOCOL), e[7:4]);
      chk(32'(CTRL.rx_active), 32'(e[7:4] != 4'h0));
      chk(32'(CTRL.modulation_am), e[10]);
      chk(32'(CTRL.auto_response_mode), e[9:8] == 2'h3 ? 2'h0 : e[9:8]);
      chk(32'(CTRL.use_passive_resistance), e[2]);
      chk(32'({RDF, RDA}), e[1:0]);
    end
    wr(md_a, 32'h0, 1'b0);
    wr(op_a, 32'h83, 1'b0);
    pulse(1'b1);
    chk(32'(CTRL.tx_active), 32'h1);
    rdchk(op_a, 32'h8B);
    pulse(1'b0);
    chk(32'(CTRL.tx_active), 32'h0);
    rdchk(op_a, 32'h83);
    wr(md_a, 32'h8, 1'b0);
    wr(op_a, 32'h81, 1'b0);
    pulse(1'b1);
    pulse(1'b0);
    rdchk(op_a, 32'h89);
    TFI <= 1'b1;
    repeat (3) @(posedge CLK);
    rdchk(nomc_pkg::ADDR_EVENT, 32'h3);
    wr(nomc_pkg::ADDR_EVENT, 32'h7, 1'b0);
    rdchk(nomc_pkg::ADDR_EVENT, 32'h0);
    POR <= 1'b1;
    repeat (2) @(posedge CLK);
    POR <= 1'b0;
    @(posedge CLK);
    rdchk(op_a, 32'h0);
    rdchk(md_a, 32'h8);
    wr(32'h40, 32'hFF, 1'b1);
    complete_run();
  end
endmodule // tb_nomc_mode_ctrl
